/* core/occ_top.sv */
/*
 * Oscillator group select control: control, trim and configuration
 * registers, guarded writes, glitch-free switch sequencing, clock-fail
 * response and the output postscaler tick.
 * Assumes the analog side reports lock, failure, new-source readiness
 * and brown-out as asynchronous levels, and the configuration word is
 * stable whenever a power-on or brown-out load occurs.
 */
// Summary of operation
// - Active group field, read-only, bits 14-12
// - Active group loads from startup config
// - Completed switch copies requested into active
// - Clock failure forces active to fast RC
// - Requested group bits 10-8, config-initialised
// - PLL/external variant from primary config
// - Divider bits 7-6: 1, 4, 16, 64
// - Bit 5 shows PLL lock
// - Fail flag sticky until software clears or a config reload
// - Bit 1 enables secondary low-power oscillator
// - Bit 0 requests switch, clears when done
// - Control bits 15,11,4,2 read zero
// - Four-bit signed fast RC trim, reset zero
// - Trim bits 15-4 read zero
// - Config word holds three fields, rest zero
// - Low byte needs keys 0x46, 0x57
// - High byte needs keys 0x78, 0x9A
// - Failure: fast RC, flag set, request cleared
// - Config 1x disables switching and monitor
`timescale 1ns/10ps
`include "occ_cfg.svh"
module occ_top
    import occ_pkg::*;
#(
    parameter int GATE_CYCLES =
        (`OCC_GATE_TIME_NS + `OCC_CLK_PERIOD_NS - 1) / `OCC_CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [23:0] cfg_word,
    input occ_sfr_req_s sfr_req,
    input occ_osc_stat_s osc_stat,
    output logic [23:0] rd_data,
    output occ_osc_ctrl_s osc_ctrl
);
    if (GATE_CYCLES < 1 || GATE_CYCLES > 255) begin : g_bad
        $error("occ_top: GATE_CYCLES must lie in 1..255");
    end

    // ------------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------------
    // The reset copy is not frozen by clk_en so release never stalls
    logic rst_meta_r;
    logic rst_n_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    occ_osc_stat_s stat_s;
    occ_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .rst_n(rst_n_r),
        .ce(clk_en),
        .din(osc_stat),
        .dout(stat_s)
    );

    // ------------------------------------------------------------------
    // Configuration capture
    // ------------------------------------------------------------------
    logic init_pend_r;
    logic reload;
    logic [23:0] cfg_r;
    logic switch_en;
    logic monitor_en;

    assign reload = init_pend_r || stat_s.bor;
    assign switch_en = !cfg_r[`OCC_CFG_SM_MSB];
    assign monitor_en = (cfg_r[`OCC_CFG_SM_MSB:`OCC_CFG_SM_LSB] == 2'b00);

    // Fuse value caught after release, never under the async reset
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            init_pend_r <= 1'b1;
            cfg_r <= 24'h000000;
        end else if (clk_en) begin
            init_pend_r <= 1'b0;
            if (reload) begin
                cfg_r <= cfg_word & `OCC_CFG_MASK;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register writes and unlock
    // ------------------------------------------------------------------
    logic wr_ctrl;
    logic lo_wr;
    logic hi_wr;
    logic lo_open;
    logic hi_open;
    logic lo_commit;
    logic hi_commit;
    logic trim_wr;

    assign wr_ctrl = sfr_req.wr && (sfr_req.idx == `OCC_IDX_CTRL);
    assign lo_wr = wr_ctrl && sfr_req.be[0];
    assign hi_wr = wr_ctrl && sfr_req.be[1];
    assign lo_commit = lo_wr && lo_open;
    assign hi_commit = hi_wr && hi_open;
    assign trim_wr = sfr_req.wr && (sfr_req.idx == `OCC_IDX_TRIM) && sfr_req.be[0];

    occ_unlock #(.KEY_A(`OCC_KEY_LO_A), .KEY_B(`OCC_KEY_LO_B)) u_unlock_lo (
        .clk(clk),
        .rst_n(rst_n_r),
        .ce(clk_en),
        .wr(lo_wr),
        .data(sfr_req.wdata[7:0]),
        .open(lo_open)
    );

    occ_unlock #(.KEY_A(`OCC_KEY_HI_A), .KEY_B(`OCC_KEY_HI_B)) u_unlock_hi (
        .clk(clk),
        .rst_n(rst_n_r),
        .ce(clk_en),
        .wr(hi_wr),
        .data(sfr_req.wdata[15:8]),
        .open(hi_open)
    );

    // ------------------------------------------------------------------
    // Clock-fail detection
    // ------------------------------------------------------------------
    logic fail_d_r;
    logic fail_evt;
    assign fail_evt = monitor_en && stat_s.fail_detect && !fail_d_r && !reload;

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            fail_d_r <= 1'b0;
        end else if (clk_en) begin
            fail_d_r <= stat_s.fail_detect;
        end
    end

    // ------------------------------------------------------------------
    // Switch sequencer
    // ------------------------------------------------------------------
    occ_state_e state_r;
    logic [7:0] gate_cnt_r;
    logic swreq_r;

    // Old clock is held stopped for GATE_CYCLES before the swap
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= ST_IDLE;
            gate_cnt_r <= 8'h00;
        end else if (clk_en) begin
            if (reload || fail_evt) begin
                state_r <= ST_IDLE;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        if (swreq_r && switch_en) begin
                            state_r <= ST_START;
                        end
                    end
                    ST_START: begin
                        if (!swreq_r) begin
                            state_r <= ST_IDLE;
                        end else if (stat_s.new_ready) begin
                            state_r <= ST_STOP;
                            gate_cnt_r <= 8'(GATE_CYCLES - 1);
                        end
                    end
                    ST_STOP: begin
                        if (!swreq_r) begin
                            state_r <= ST_IDLE;
                        end else if (gate_cnt_r == 8'h00) begin
                            state_r <= ST_SWAP;
                        end else begin
                            gate_cnt_r <= gate_cnt_r - 8'h01;
                        end
                    end
                    ST_SWAP: begin
                        state_r <= ST_IDLE;
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Control register state
    // ------------------------------------------------------------------
    logic [2:0] active_r;
    logic [2:0] requested_r;
    logic [1:0] divider_r;
    logic fail_flag_r;
    logic lpen_r;
    logic [3:0] trim_r;

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            active_r <= `OCC_GRP_FASTRC;
        end else if (clk_en) begin
            if (reload) begin
                active_r <= cfg_word[`OCC_CFG_START_MSB:`OCC_CFG_START_LSB];
            end else if (fail_evt) begin
                active_r <= `OCC_GRP_FASTRC;
            end else if (state_r == ST_SWAP) begin
                active_r <= requested_r;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            requested_r <= `OCC_GRP_FASTRC;
        end else if (clk_en) begin
            if (reload) begin
                requested_r <= cfg_word[`OCC_CFG_START_MSB:`OCC_CFG_START_LSB];
            end else if (hi_commit) begin
                requested_r <= sfr_req.wdata[`OCC_REQ_MSB:`OCC_REQ_LSB];
            end
        end
    end

    // Hardware clears beat a software set in the same cycle
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            swreq_r <= 1'b0;
        end else if (clk_en) begin
            if (reload || fail_evt || state_r == ST_SWAP) begin
                swreq_r <= 1'b0;
            end else if (lo_commit) begin
                swreq_r <= sfr_req.wdata[`OCC_SWREQ_BIT] && switch_en;
            end
        end
    end

    // A failure in the clearing cycle keeps the flag set
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            fail_flag_r <= 1'b0;
        end else if (clk_en) begin
            if (reload) begin
                fail_flag_r <= 1'b0;
            end else if (fail_evt) begin
                fail_flag_r <= 1'b1;
            end else if (lo_commit && !sfr_req.wdata[`OCC_FAIL_BIT]) begin
                fail_flag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            divider_r <= 2'h0;
            lpen_r <= 1'b0;
        end else if (clk_en && lo_commit) begin
            divider_r <= sfr_req.wdata[`OCC_DIV_MSB:`OCC_DIV_LSB];
            lpen_r <= sfr_req.wdata[`OCC_LPEN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            trim_r <= `OCC_TRIM_RST;
        end else if (clk_en && trim_wr) begin
            trim_r <= sfr_req.wdata[`OCC_TRIM_MSB:0];
        end
    end

    // ------------------------------------------------------------------
    // Postscaler tick
    // ------------------------------------------------------------------
    logic [5:0] div_cnt_r;
    logic [5:0] div_lim;
    logic tick_nxt;

    always_comb begin
        case (divider_r)
            2'h0: div_lim = `OCC_DIV_LIM_1;
            2'h1: div_lim = `OCC_DIV_LIM_4;
            2'h2: div_lim = `OCC_DIV_LIM_16;
            default: div_lim = `OCC_DIV_LIM_64;
        endcase
    end
    assign tick_nxt = (div_cnt_r >= div_lim);

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            div_cnt_r <= 6'h00;
        end else if (clk_en) begin
            div_cnt_r <= tick_nxt ? 6'h00 : div_cnt_r + 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // Read data and outputs
    // ------------------------------------------------------------------
    logic [23:0] rd_data_r;
    occ_osc_ctrl_s osc_ctrl_r;
    logic prim_grp;
    assign prim_grp = (active_r == `OCC_GRP_PLL) || (active_r == `OCC_GRP_EXT);

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rd_data_r <= 24'h000000;
        end else if (clk_en) begin
            case (sfr_req.idx)
                `OCC_IDX_CTRL: rd_data_r <= {8'h00, 1'b0, active_r, 1'b0, requested_r,
                    divider_r, stat_s.pll_locked, 1'b0, fail_flag_r, 1'b0,
                    lpen_r, swreq_r};
                `OCC_IDX_TRIM: rd_data_r <= {20'h00000, trim_r};
                `OCC_IDX_CFG: rd_data_r <= cfg_r;
                default: rd_data_r <= 24'h000000;
            endcase
        end
    end

    // Variant bits only matter for PLL and external groups
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            osc_ctrl_r <= '0;
        end else if (clk_en) begin
            osc_ctrl_r.source_group <= active_r;
            osc_ctrl_r.primary_variant <= prim_grp ?
                cfg_r[`OCC_CFG_VAR_MSB:`OCC_CFG_VAR_LSB] : 5'h00;
            osc_ctrl_r.start_group <= requested_r;
            osc_ctrl_r.start_new <= (state_r != ST_IDLE);
            osc_ctrl_r.stop_old <= (state_r == ST_STOP) || (state_r == ST_SWAP);
            osc_ctrl_r.divider <= divider_r;
            osc_ctrl_r.lowpower_en <= lpen_r;
            osc_ctrl_r.trim <= trim_r;
            osc_ctrl_r.fail_trap <= fail_evt;
            osc_ctrl_r.output_divider_select_tick <= tick_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign osc_ctrl = osc_ctrl_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_r);

    sequence s_lo_keys;
        clk_en && !reload && lo_wr && sfr_req.wdata[7:0] == `OCC_KEY_LO_A ##1
        clk_en && !reload && lo_wr && sfr_req.wdata[7:0] == `OCC_KEY_LO_B;
    endsequence

    sequence s_stop_done;
        clk_en && state_r == ST_STOP && gate_cnt_r == 8'h00 && swreq_r
        && !fail_evt && !reload;
    endsequence

    a_fail_forces_fastrc: assert property (
        clk_en && fail_evt |=> active_r == `OCC_GRP_FASTRC && fail_flag_r && !swreq_r)
        else $error("clock failure did not force fast RC");

    a_fail_flag_held: assert property (
        clk_en && fail_flag_r && !reload && !(lo_commit && !sfr_req.wdata[`OCC_FAIL_BIT])
        |=> fail_flag_r)
        else $error("clock fail flag dropped without a clear");

    a_swap_copies_req: assert property (
        clk_en && state_r == ST_SWAP && !fail_evt && !reload
        |=> active_r == $past(requested_r) && !swreq_r && state_r == ST_IDLE)
        else $error("switch completion did not copy requested group");

    a_lo_unlock_write: assert property (
        s_lo_keys ##1 (clk_en && lo_wr && !reload)
        |=> divider_r == $past(sfr_req.wdata[`OCC_DIV_MSB:`OCC_DIV_LSB]))
        else $error("unlocked low byte write not taken");

    a_lo_locked_write: assert property (
        clk_en && lo_wr && !lo_open |=> $stable(divider_r) && $stable(lpen_r))
        else $error("locked low byte write took effect");

    a_hi_locked_write: assert property (
        clk_en && hi_wr && !hi_open && !reload |=> $stable(requested_r))
        else $error("locked high byte write took effect");

    a_switch_disabled: assert property (
        !switch_en && !reload |-> state_r == ST_IDLE && !swreq_r)
        else $error("switching active while disabled by config");

    a_abort_switch: assert property (
        clk_en && state_r == ST_START && !swreq_r && !reload |=> state_r == ST_IDLE)
        else $error("cleared request did not abort switch");

    a_stop_then_swap: assert property (
        s_stop_done |=> state_r == ST_SWAP && osc_ctrl.stop_old)
        else $error("old clock stop did not lead to swap");

    a_div_pass_tick: assert property (
        clk_en && divider_r == 2'h0 |=> osc_ctrl.output_divider_select_tick)
        else $error("undivided setting missed a tick");

    // Trim bit 2 is live state, so control and trim need separate masks
    a_ctrl_reserved: assert property (
        clk_en && sfr_req.idx == `OCC_IDX_CTRL |=> rd_data[23:16] == 8'h00
        && !rd_data[15] && !rd_data[11] && !rd_data[4] && !rd_data[2])
        else $error("reserved control read bits not zero");

    a_trim_reserved: assert property (
        clk_en && sfr_req.idx == `OCC_IDX_TRIM |=> rd_data[23:4] == 20'h00000)
        else $error("reserved trim read bits not zero");
endmodule

/* core/occ_cfg.svh */
/*
 * Offsets, field positions, codes, keys and timing for the oscillator
 * group select control. Assumes inclusion by bare name from core/.
 */
`ifndef OCC_CFG_SVH
`define OCC_CFG_SVH

// ----------------------------------------------------------------------
// Register indices on the special function register port
// ----------------------------------------------------------------------
`define OCC_IDX_CTRL 2'h0
`define OCC_IDX_TRIM 2'h1
`define OCC_IDX_CFG 2'h2

// ----------------------------------------------------------------------
// Control and trim register fields
// ----------------------------------------------------------------------
`define OCC_ACT_MSB 14
`define OCC_ACT_LSB 12
`define OCC_REQ_MSB 10
`define OCC_REQ_LSB 8
`define OCC_DIV_MSB 7
`define OCC_DIV_LSB 6
`define OCC_LOCK_BIT 5
`define OCC_FAIL_BIT 3
`define OCC_LPEN_BIT 1
`define OCC_SWREQ_BIT 0
`define OCC_TRIM_MSB 3
`define OCC_TRIM_RST 4'h0

// ----------------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------------
`define OCC_CFG_SM_MSB 15
`define OCC_CFG_SM_LSB 14
`define OCC_CFG_START_MSB 10
`define OCC_CFG_START_LSB 8
`define OCC_CFG_VAR_MSB 4
`define OCC_CFG_VAR_LSB 0
`define OCC_CFG_MASK 24'h00c71f

// ----------------------------------------------------------------------
// Source group codes, unlock keys, divider limits, timing
// ----------------------------------------------------------------------
`define OCC_GRP_PLL 3'h7
`define OCC_GRP_EXT 3'h3
`define OCC_GRP_SLOWRC 3'h2
`define OCC_GRP_FASTRC 3'h1
`define OCC_GRP_SECXTAL 3'h0
`define OCC_KEY_LO_A 8'h46
`define OCC_KEY_LO_B 8'h57
`define OCC_KEY_HI_A 8'h78
`define OCC_KEY_HI_B 8'h9a
`define OCC_DIV_LIM_1 6'h00
`define OCC_DIV_LIM_4 6'h03
`define OCC_DIV_LIM_16 6'h0f
`define OCC_DIV_LIM_64 6'h3f
`define OCC_GATE_TIME_NS 16
`define OCC_CLK_PERIOD_NS 8

`endif

/* core/occ_pkg.sv */
/*
 * Types of the oscillator group select control: switch states and the
 * bundles carried on the ports. Assumes nothing of its surroundings.
 */
package occ_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_START = 4'h2,
        ST_STOP = 4'h4,
        ST_SWAP = 4'h8
    } occ_state_e;

    typedef struct packed {
        logic wr;
        logic [1:0] idx;
        logic [1:0] be;
        logic [15:0] wdata;
    } occ_sfr_req_s;

    typedef struct packed {
        logic pll_locked;
        logic fail_detect;
        logic new_ready;
        logic bor;
    } occ_osc_stat_s;

    typedef struct packed {
        logic [2:0] source_group;
        logic [4:0] primary_variant;
        logic [2:0] start_group;
        logic start_new;
        logic stop_old;
        logic [1:0] divider;
        logic lowpower_en;
        logic [3:0] trim;
        logic fail_trap;
        logic output_divider_select_tick;
    } occ_osc_ctrl_s;

endpackage

/* core/occ_sync.sv */
/*
 * Three-stage input synchroniser, one per bit. Assumes inputs come from
 * outside the clk domain; the output moves only once stages two and
 * three agree.
 */
`timescale 1ns/10ps
module occ_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    if (WIDTH < 1) begin : g_bad
        $error("occ_sync: WIDTH must be at least 1");
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic s1_r;
        logic s2_r;
        logic s3_r;
        logic out_r;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                s1_r <= 1'b0;
                s2_r <= 1'b0;
                s3_r <= 1'b0;
                out_r <= 1'b0;
            end else if (ce) begin
                s1_r <= din[i];
                s2_r <= s1_r;
                s3_r <= s2_r;
                if (s2_r == s3_r) begin
                    out_r <= s3_r;
                end
            end
        end
        assign dout[i] = out_r;
    end
endmodule

/* core/occ_unlock.sv */
/*
 * Two-key unlock for one byte lane. Assumes wr pulses once per byte
 * write on this lane; open is high for the single cycle after the keys.
 */
`timescale 1ns/10ps
module occ_unlock #(
    parameter logic [7:0] KEY_A = 8'h00,
    parameter logic [7:0] KEY_B = 8'h00
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wr,
    input wire logic [7:0] data,
    output logic open
);
    logic armed_r;
    logic open_r;

    // Any other access in between breaks the sequence
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_r <= 1'b0;
            open_r <= 1'b0;
        end else if (ce) begin
            armed_r <= wr && (data == KEY_A);
            open_r <= wr && armed_r && (data == KEY_B);
        end
    end

    assign open = open_r;
endmodule

/* tb/occ_top_tb.sv */
/*
 * Self-checking bench for the oscillator group select control.
 * Assumes the register port contract of occ_top and a 125 MHz clock.
 */
`timescale 1ns/10ps
module occ_top_tb;
    import occ_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [23:0] cfg_word = 24'hff3ba5;
    occ_sfr_req_s sfr_req = '0;
    occ_osc_stat_s osc_stat = '0;
    logic [23:0] rd_data;
    occ_osc_ctrl_s osc_ctrl;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    int cnt;
    int i;

    occ_top #(.GATE_CYCLES(2)) DUT (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .cfg_word(cfg_word), .sfr_req(sfr_req), .osc_stat(osc_stat), .rd_data(rd_data),
        .osc_ctrl(osc_ctrl));

    always #4 clk = ~clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Generous ceiling: the sequence needs well under 2000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            summarize();
        end
    end

    task automatic chk(input logic [23:0] s, input logic [23:0] e);
        samples_checked = samples_checked + 1;
        if (s !== e) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr1(input logic [1:0] idx, input logic [1:0] be, input logic [15:0] d);
        sfr_req = {1'b1, idx, be, d};
        cyc(1);
        sfr_req.wr = 1'b0;
        // Idle edge so a following call never re-raises wr in one step
        cyc(1);
    endtask

    // Keys and data on three back-to-back cycles, strobe held high between them
    task automatic unl(input logic [1:0] be, input logic [15:0] k1, input logic [15:0] k2,
                       input logic [15:0] d);
        sfr_req = {1'b1, 2'h0, be, k1};
        cyc(1);
        sfr_req.wdata = k2;
        cyc(1);
        sfr_req.wdata = d;
        cyc(1);
        sfr_req.wr = 1'b0;
        cyc(1);
    endtask

    task automatic rd(input logic [1:0] idx, input logic [23:0] e);
        sfr_req.idx = idx;
        cyc(2);
        chk(rd_data, e);
    endtask

    task automatic wait_start();
        for (i = 0; i < 40 && osc_ctrl.start_new !== 1'b1; i++) cyc(1);
    endtask

    task automatic wait_grp(input logic [2:0] g);
        for (i = 0; i < 60 && osc_ctrl.source_group !== g; i++) cyc(1);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        cyc(12);
        reset_n = 1'b1;
        cyc(6);
        rd(2'h2, 24'h000305);
        rd(2'h0, 24'h003300);
        chk(osc_ctrl.primary_variant, 24'h5);
        rd(2'h1, 24'h0);
        wr1(2'h1, 2'b11, 16'hfff8);
        rd(2'h1, 24'h000008);
        chk(osc_ctrl.trim, 24'h8);
        wr1(2'h0, 2'b01, 16'h00d6);
        rd(2'h0, 24'h003300);
        unl(2'b01, 16'h0046, 16'h0057, 16'h00d6);
        rd(2'h0, 24'h0033c2);
        chk({osc_ctrl.divider, osc_ctrl.lowpower_en}, 24'h7);
        cnt = 0;
        repeat (128) begin
            cyc(1);
            cnt = cnt + osc_ctrl.output_divider_select_tick;
        end
        chk(cnt[23:0], 24'h2);
        unl(2'b10, 16'h7800, 16'h9a00, 16'hf900);
        rd(2'h0, 24'h0031c2);
        // Switch to fast RC, the new source reports ready only after start
        unl(2'b01, 16'h0046, 16'h0057, 16'h00c3);
        rd(2'h0, 24'h0031c3);
        wait_start();
        chk(osc_ctrl.start_new, 24'h1);
        osc_stat.new_ready = 1'b1;
        wait_grp(3'h1);
        osc_stat.new_ready = 1'b0;
        rd(2'h0, 24'h0011c2);
        // Abort a pending switch by clearing the request
        unl(2'b10, 16'h7800, 16'h9a00, 16'h7700);
        unl(2'b01, 16'h0046, 16'h0057, 16'h00c3);
        wait_start();
        unl(2'b01, 16'h0046, 16'h0057, 16'h00c2);
        cyc(10);
        rd(2'h0, 24'h0017c2);
        chk(osc_ctrl.start_new, 24'h0);
        chk(osc_ctrl.start_group, 24'h7);
        // Complete a switch to the PLL group, then fail it
        osc_stat.new_ready = 1'b1;
        osc_stat.pll_locked = 1'b1;
        unl(2'b01, 16'h0046, 16'h0057, 16'h00c3);
        // Old clock gated for two stop cycles plus the swap cycle
        cnt = 0;
        repeat (20) begin
            cyc(1);
            cnt = cnt + osc_ctrl.stop_old;
        end
        chk(cnt[23:0], 24'h3);
        chk(osc_ctrl.source_group, 24'h7);
        osc_stat.new_ready = 1'b0;
        rd(2'h0, 24'h0077e2);
        osc_stat.fail_detect = 1'b1;
        cnt = 0;
        repeat (12) begin
            cyc(1);
            cnt = cnt + osc_ctrl.fail_trap;
        end
        chk(cnt[23:0], 24'h1);
        rd(2'h0, 24'h0017ea);
        rd(2'h0, 24'h0017ea);
        unl(2'b01, 16'h0046, 16'h0057, 16'h00c2);
        rd(2'h0, 24'h0017e2);
        osc_stat.fail_detect = 1'b0;
        // Brown-out reload with switching and monitor disabled
        cfg_word = 24'hffbba5;
        osc_stat.bor = 1'b1;
        cyc(8);
        osc_stat.bor = 1'b0;
        cyc(8);
        rd(2'h0, 24'h0033e2);
        rd(2'h2, 24'h008305);
        unl(2'b01, 16'h0046, 16'h0057, 16'h00c3);
        rd(2'h0, 24'h0033e2);
        osc_stat.fail_detect = 1'b1;
        cyc(10);
        rd(2'h0, 24'h0033e2);
        rd(2'h3, 24'h0);
        summarize();
    end
endmodule
